// File: inc/asp_pkg.sv
package asp_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int CODE_W = 24;

    typedef logic [WORD_W-1:0] asp_word_t;
    typedef logic [7:0] asp_byte_t;

    // ----------------------------------------------------------------
    // Resynchronisation sequence
    // ----------------------------------------------------------------
    localparam asp_byte_t RESYNC_FILL_COMMAND = 8'hFF;
    localparam asp_byte_t RESYNC_TERMINATE_COMMAND = 8'hFE;
    localparam logic [3:0] FILL_COUNT = 4'hF;

    // ----------------------------------------------------------------
    // Command bytes
    // ----------------------------------------------------------------
    localparam asp_byte_t CMD_WRITE_CFG = 8'h03;
    localparam asp_byte_t CMD_READ_CFG = 8'h0B;
    localparam asp_byte_t CMD_READ_DATA = 8'h0C;

    // ----------------------------------------------------------------
    // Configuration word layout
    // ----------------------------------------------------------------
    localparam int CFG_SYS_RESET_BIT = 29;
    localparam int CFG_A1_BIT = 27;
    localparam int CFG_A0_BIT = 26;
    localparam int CFG_UNIPOLAR_BIT = 10;
    localparam asp_word_t CFG_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Result word layout
    // ----------------------------------------------------------------
    localparam int DATA_CODE_LSB = 8;
    localparam int DATA_OVR_BIT = 2;

    // ----------------------------------------------------------------
    // Bit counters
    // ----------------------------------------------------------------
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [4:0] WORD_LAST = 5'h1F;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CMD = 2'b00,
        MODE_WRITE_CFG = 2'b01,
        MODE_READ = 2'b10
    } asp_mode_e;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic overrange_flag;
    } asp_result_s;

    typedef struct packed {
        asp_mode_e mode;
        logic [2:0] byte_bit;
        logic [4:0] word_bit;
        logic [3:0] ff_cnt;
        asp_word_t shin;
        asp_word_t out_sh;
        asp_word_t cfg;
        asp_word_t data_word;
        logic sout;
        logic ack;
    } asp_link_s;

    typedef struct packed {
        asp_word_t hold;
        logic req;
    } asp_sys_s;

    localparam asp_link_s LINK_RESET = '{mode: MODE_CMD, byte_bit: 3'h0, word_bit: 5'h00, ff_cnt: 4'h0,
                                         shin: 32'h0000_0000, out_sh: 32'h0000_0000, cfg: CFG_RESET,
                                         data_word: 32'h0000_0000, sout: 1'b0, ack: 1'b0};
    localparam asp_sys_s SYS_RESET = '{hold: 32'h0000_0000, req: 1'b0};

endpackage

// File: verilog/asp_sync.sv
// Two-stage level synchroniser, one pair of flops per bit
module asp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                meta_reg[i] <= 1'b0;
                q[i] <= 1'b0;
            end else begin
                meta_reg[i] <= d[i];
                q[i] <= meta_reg[i];
            end
        end
    end

endmodule // asp_sync

// File: verilog/asp_port.sv
// Function
// - Fifteen fill bytes then one terminate byte, sent on the port's byte boundaries, return the port to command mode from any mode.
// - Serial clock edges count only while chip select is low.
// - The serial output is released whenever chip select is high.
// - One input bit is taken per serial clock.
// - One output bit is shifted per serial clock, the same clock as the input.
// - The two logic outputs follow their configuration bits at all times.
// - Polarity bit one selects unipolar mode, zero bipolar.
// - A result reads as a 32-bit word, MSB first, overrange flag in the last byte.
module asp_port (
    // Clocks and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    // Serial pins
    input wire logic cs_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Logic outputs
    output logic logic_output_bit0,
    output logic logic_output_bit1,
    // Converter core
    input wire logic result_valid,
    input wire asp_pkg::asp_result_s result,
    output logic unipolar_mode
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    asp_pkg::asp_link_s link_reg;
    asp_pkg::asp_link_s link_next;
    asp_pkg::asp_sys_s sys_reg;
    asp_pkg::asp_sys_s sys_next;

    logic req_sync;
    logic [1:0] sys_sync;
    asp_pkg::asp_byte_t rx_byte;
    asp_pkg::asp_word_t rx_word;
    logic byte_end;
    logic resync_hit;

    assign rx_byte = {link_reg.shin[6:0], serial_in};
    assign rx_word = {link_reg.shin[30:0], serial_in};
    assign byte_end = (link_reg.byte_bit == asp_pkg::BYTE_LAST);
    // Detection looks at byte boundaries only; a byte cut short by the host
    // shifts alignment until the next reset, since the bit count never realigns
    // resync detect
    assign resync_hit = byte_end && (rx_byte == asp_pkg::RESYNC_TERMINATE_COMMAND) &&
                        (link_reg.ff_cnt == asp_pkg::FILL_COUNT);

    // ----------------------------------------------------------------
    // Crossings
    // ----------------------------------------------------------------
    asp_sync #(.WIDTH(1)) u_req_sync (
        .clk(sclk),
        .nrst(nrst),
        .d(sys_reg.req),
        .q(req_sync)
    );

    // Bit 1 carries polarity, bit 0 the handshake return
    asp_sync #(.WIDTH(2)) u_sys_sync (
        .clk(mclk),
        .nrst(nrst),
        .d({link_reg.cfg[asp_pkg::CFG_UNIPOLAR_BIT], link_reg.ack}),
        .q(sys_sync)
    );

    // ----------------------------------------------------------------
    // Result capture, system clock
    // ----------------------------------------------------------------
    // Holding word stays frozen until the link side returns the toggle;
    // results offered meanwhile are dropped, the link may be idle for long.
    always_comb begin
        sys_next = sys_reg;
        if ((sys_reg.req == sys_sync[0]) && result_valid) begin
            sys_next.hold = '0;
            sys_next.hold[asp_pkg::DATA_CODE_LSB +: asp_pkg::CODE_W] = result.code;
            sys_next.hold[asp_pkg::DATA_OVR_BIT] = result.overrange_flag;
            sys_next.req = ~sys_reg.req;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sys_reg <= asp_pkg::SYS_RESET;
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign unipolar_mode = sys_sync[1];

    // ----------------------------------------------------------------
    // Serial engine, link clock
    // ----------------------------------------------------------------
    always_comb begin
        link_next = link_reg;
        // select assumed stable at rising edges
        if (!cs_n) begin
            link_next.shin = rx_word;
            link_next.byte_bit = link_reg.byte_bit + 3'h1;
            if (req_sync != link_reg.ack) begin
                link_next.data_word = sys_reg.hold;
                link_next.ack = req_sync;
            end
            if (byte_end) begin
                if (rx_byte == asp_pkg::RESYNC_FILL_COMMAND) begin
                    if (link_reg.ff_cnt != asp_pkg::FILL_COUNT) begin
                        link_next.ff_cnt = link_reg.ff_cnt + 4'h1;
                    end
                end else begin
                    link_next.ff_cnt = 4'h0;
                end
            end
            if (resync_hit) begin
                link_next.mode = asp_pkg::MODE_CMD;
                link_next.word_bit = 5'h00;
                link_next.sout = 1'b0;
            end else begin
                unique case (link_reg.mode)
                    asp_pkg::MODE_CMD: begin
                        if (byte_end) begin
                            link_next.word_bit = 5'h00;
                            if (rx_byte == asp_pkg::CMD_WRITE_CFG) begin
                                link_next.mode = asp_pkg::MODE_WRITE_CFG;
                            end else if (rx_byte == asp_pkg::CMD_READ_CFG) begin
                                link_next.mode = asp_pkg::MODE_READ;
                                link_next.sout = link_reg.cfg[31];
                                link_next.out_sh = {link_reg.cfg[30:0], 1'b0};
                            end else if (rx_byte == asp_pkg::CMD_READ_DATA) begin
                                link_next.mode = asp_pkg::MODE_READ;
                                link_next.sout = link_reg.data_word[31];
                                link_next.out_sh = {link_reg.data_word[30:0], 1'b0};
                            end
                        end
                    end
                    asp_pkg::MODE_WRITE_CFG: begin
                        link_next.word_bit = link_reg.word_bit + 5'h01;
                        if (link_reg.word_bit == asp_pkg::WORD_LAST) begin
                            link_next.mode = asp_pkg::MODE_CMD;
                            if (rx_word[asp_pkg::CFG_SYS_RESET_BIT]) begin
                                link_next.cfg = asp_pkg::CFG_RESET;
                            end else begin
                                link_next.cfg = rx_word;
                            end
                        end
                    end
                    asp_pkg::MODE_READ: begin
                        link_next.word_bit = link_reg.word_bit + 5'h01;
                        if (link_reg.word_bit == asp_pkg::WORD_LAST) begin
                            link_next.mode = asp_pkg::MODE_CMD;
                            link_next.sout = 1'b0;
                        end else begin
                            link_next.sout = link_reg.out_sh[31];
                            link_next.out_sh = {link_reg.out_sh[30:0], 1'b0};
                        end
                    end
                    default: begin
                        link_next.mode = asp_pkg::MODE_CMD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            link_reg <= asp_pkg::LINK_RESET;
        end else begin
            link_reg <= link_next;
        end
    end

    // release output when deselected
    // Cleared by select itself, since the link clock stops between frames
    always_ff @(posedge sclk or posedge cs_n or negedge nrst) begin
        if (!nrst) begin
            serial_out_oe <= 1'b0;
        end else if (cs_n) begin
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign serial_out = link_reg.sout;
    assign logic_output_bit0 = link_reg.cfg[asp_pkg::CFG_A0_BIT];
    assign logic_output_bit1 = link_reg.cfg[asp_pkg::CFG_A1_BIT];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    resync_mode_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && resync_hit) |=> (link_reg.mode == asp_pkg::MODE_CMD && link_reg.word_bit == 5'h00 &&
                                   link_reg.ff_cnt == 4'h0 && !serial_out))
        else $error("resync sequence did not restore command mode");

    cs_hold_a: assert property (@(posedge sclk) disable iff (!nrst)
        cs_n |=> $stable(link_reg))
        else $error("link state moved while deselected");

    edge_ignore_a: assert property (@(posedge sclk) disable iff (!nrst)
        cs_n |=> (link_reg.byte_bit == $past(link_reg.byte_bit) && link_reg.word_bit == $past(link_reg.word_bit)))
        else $error("bit count advanced with select high");

    byte_count_a: assert property (@(posedge sclk) disable iff (!nrst)
        !cs_n |=> link_reg.byte_bit == $past(link_reg.byte_bit) + 3'h1)
        else $error("bit count did not advance by one per clock");

    fill_clear_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && byte_end && rx_byte != asp_pkg::RESYNC_FILL_COMMAND) |=> link_reg.ff_cnt == 4'h0)
        else $error("fill count kept after another byte");

    fill_count_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && byte_end && rx_byte == asp_pkg::RESYNC_FILL_COMMAND) |=> link_reg.ff_cnt != 4'h0)
        else $error("fill byte not counted");

    oe_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        cs_n |-> !serial_out_oe)
        else $error("serial output driven while deselected");

    shift_in_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n ##1 !cs_n) |=> link_reg.shin[1:0] == {$past(serial_in, 2), $past(serial_in)})
        else $error("input bits not taken one per clock");

    shift_out_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && !resync_hit && link_reg.mode == asp_pkg::MODE_READ && link_reg.word_bit != asp_pkg::WORD_LAST)
        |=> serial_out == $past(link_reg.out_sh[31]))
        else $error("output bit not shifted on clock");

    read_cfg_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && !resync_hit && byte_end && link_reg.mode == asp_pkg::MODE_CMD && rx_byte == asp_pkg::CMD_READ_CFG)
        |=> (link_reg.mode == asp_pkg::MODE_READ && serial_out == $past(link_reg.cfg[31])))
        else $error("configuration read did not start with its MSB");

    read_end_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && !resync_hit && link_reg.mode == asp_pkg::MODE_READ && link_reg.word_bit == asp_pkg::WORD_LAST)
        |=> (link_reg.mode == asp_pkg::MODE_CMD && !serial_out))
        else $error("read did not end after the last word bit");

    read_start_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && !resync_hit && byte_end && link_reg.mode == asp_pkg::MODE_CMD && rx_byte == asp_pkg::CMD_READ_DATA)
        |=> (link_reg.mode == asp_pkg::MODE_READ && serial_out == $past(link_reg.data_word[31])))
        else $error("result read did not start with its MSB");

    data_pad_a: assert property (@(posedge sclk) disable iff (!nrst)
        link_reg.data_word[7:3] == 5'h00 && link_reg.data_word[1:0] == 2'h0)
        else $error("result word padding bits not zero");

    pins_follow_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && !resync_hit && link_reg.mode == asp_pkg::MODE_WRITE_CFG && link_reg.word_bit == asp_pkg::WORD_LAST
         && !rx_word[asp_pkg::CFG_SYS_RESET_BIT])
        |=> (logic_output_bit1 == $past(rx_word[asp_pkg::CFG_A1_BIT]) &&
             logic_output_bit0 == $past(rx_word[asp_pkg::CFG_A0_BIT])))
        else $error("logic outputs do not follow written configuration");

    cfg_clear_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && !resync_hit && link_reg.mode == asp_pkg::MODE_WRITE_CFG && link_reg.word_bit == asp_pkg::WORD_LAST
         && rx_word[asp_pkg::CFG_SYS_RESET_BIT])
        |=> (link_reg.cfg == asp_pkg::CFG_RESET && !logic_output_bit0 && !logic_output_bit1))
        else $error("system reset write did not restore defaults");

    handoff_a: assert property (@(posedge sclk) disable iff (!nrst)
        (!cs_n && req_sync != link_reg.ack)
        |=> (link_reg.data_word == $past(sys_reg.hold) && link_reg.ack == $past(req_sync)))
        else $error("result word not taken on handshake");

    hold_stable_a: assert property (@(posedge mclk) disable iff (!nrst)
        (sys_reg.req != sys_sync[0]) |=> $stable(sys_reg.hold))
        else $error("result word changed while handshake pending");

    polarity_a: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(link_reg.cfg[asp_pkg::CFG_UNIPOLAR_BIT])
        |-> ##[1:3] unipolar_mode == link_reg.cfg[asp_pkg::CFG_UNIPOLAR_BIT])
        else $error("polarity output did not follow configuration");

    resync_seen_c: cover property (@(posedge sclk) disable iff (!nrst) !cs_n && resync_hit);
    cfg_write_c: cover property (@(posedge sclk) disable iff (!nrst)
        !cs_n && link_reg.mode == asp_pkg::MODE_WRITE_CFG && link_reg.word_bit == asp_pkg::WORD_LAST);
    data_read_c: cover property (@(posedge sclk) disable iff (!nrst)
        !cs_n && byte_end && link_reg.mode == asp_pkg::MODE_CMD && rx_byte == asp_pkg::CMD_READ_DATA);
    handoff_c: cover property (@(posedge sclk) disable iff (!nrst) !cs_n && req_sync != link_reg.ack);
    resume_c: cover property (@(posedge sclk) disable iff (!nrst)
        cs_n ##1 (!cs_n && link_reg.mode == asp_pkg::MODE_READ));

endmodule // asp_port

// File: verification/asp_host_model.sv
module asp_host_model (
    // Serial pins driven by the host
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    // Resolved serial data line
    input wire logic sdo_wire
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [63:0] rx;

    // Crystal start-up wait, scaled down to keep runs short
    localparam int STARTUP_NS = 2000;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        rx = 64'h0;
    end

    task automatic startup();
        #STARTUP_NS;
    endtask

    task automatic sel();
        #11 cs_n = 1'b0;
        #8;
    endtask

    task automatic desel();
        #8 cs_n = 1'b1;
        serial_in = ~serial_in;
        #8;
    endtask

    task automatic shift(input int n, input logic [63:0] d);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = d[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
            rx = {rx[62:0], sdo_wire};
        end
    endtask

    // Deliberate clock activity while deselected
    task automatic stray(input int n);
        repeat (n) begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
    endtask

    task automatic resync();
        repeat (15) shift(8, {56'h0, asp_pkg::RESYNC_FILL_COMMAND});
        shift(8, {56'h0, asp_pkg::RESYNC_TERMINATE_COMMAND});
    endtask

    task automatic write_cfg(input asp_pkg::asp_word_t w);
        shift(40, {24'h0, asp_pkg::CMD_WRITE_CFG, w});
    endtask

    task automatic read(input asp_pkg::asp_byte_t cmd, output asp_pkg::asp_word_t w);
        shift(40, {24'h0, cmd, 32'h0000_0000});
        w = rx[32:1];
    endtask
endmodule // asp_host_model

// File: verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk;
    logic nrst;
    wire logic sclk;
    wire logic cs_n;
    wire logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    logic lo0;
    logic lo1;
    logic result_valid;
    asp_pkg::asp_result_s result;
    logic unipolar_mode;
    logic sdo_last;
    wire logic sdo_wire;
    int error_cnt;
    int num_checks;
    asp_pkg::asp_word_t w;
    asp_pkg::asp_word_t r;
    asp_pkg::asp_word_t last_cfg;
    logic [31:0] seed_dummy;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Released line shows the inverse of its last driven value
    initial sdo_last = 1'b0;
    always @(serial_out or serial_out_oe) if (serial_out_oe) sdo_last = serial_out;
    assign sdo_wire = serial_out_oe ? serial_out : ~sdo_last;

    asp_port dut (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .logic_output_bit0(lo0), .logic_output_bit1(lo1),
        .result_valid(result_valid), .result(result), .unipolar_mode(unipolar_mode)
    );

    asp_host_model host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .sdo_wire(sdo_wire));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    function automatic asp_pkg::asp_word_t cfg_expect(input asp_pkg::asp_word_t v);
        return v[asp_pkg::CFG_SYS_RESET_BIT] ? asp_pkg::CFG_RESET : v;
    endfunction

    function automatic asp_pkg::asp_word_t result_expect(input asp_pkg::asp_result_s s);
        return {s.code, 5'h00, s.overrange_flag, 2'h0};
    endfunction

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #900000;
        $display("Error at %0t: run did not finish", $time);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        error_cnt = 0;
        num_checks = 0;
        nrst = 1'b0;
        result_valid = 1'b0;
        result = '0;
        seed_dummy = $urandom(32'h7805);
        repeat (6) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        check({31'h0, serial_out_oe}, 32'h0);
        check({30'h0, lo1, lo0}, 32'h0);
        check({31'h0, unipolar_mode}, 32'h0);
        host.startup();
        host.sel();
        host.resync();
        host.write_cfg(32'h2000_0000);
        host.read(asp_pkg::CMD_READ_CFG, r);
        check(r, 32'h0000_0000);
        for (int k = 0; k < 6; k++) begin
            w = $urandom;
            w[asp_pkg::CFG_SYS_RESET_BIT] = (k == 4);
            w[asp_pkg::CFG_A1_BIT] = k[1];
            w[asp_pkg::CFG_A0_BIT] = k[0];
            w[asp_pkg::CFG_UNIPOLAR_BIT] = k[0] ^ k[1];
            host.write_cfg(w);
            last_cfg = cfg_expect(w);
            check({30'h0, lo1, lo0}, {30'h0, last_cfg[asp_pkg::CFG_A1_BIT], last_cfg[asp_pkg::CFG_A0_BIT]});
            repeat (4) @(negedge mclk);
            check({31'h0, unipolar_mode}, {31'h0, last_cfg[asp_pkg::CFG_UNIPOLAR_BIT]});
            host.read(asp_pkg::CMD_READ_CFG, r);
            check(r, last_cfg);
        end
        for (int k = 0; k < 3; k++) begin
            @(negedge mclk);
            result_valid = 1'b1;
            w = $urandom;
            result.code = w[asp_pkg::CODE_W-1:0];
            result.overrange_flag = (k != 1);
            @(negedge mclk);
            result_valid = 1'b0;
            repeat (8) @(negedge mclk);
            host.read(asp_pkg::CMD_READ_DATA, r);
            check(r, result_expect(result));
        end
        host.shift(20, {44'h0, asp_pkg::CMD_READ_CFG, 12'h000});
        host.desel();
        check({31'h0, serial_out_oe}, 32'h0);
        host.stray(5);
        check({31'h0, serial_out_oe}, 32'h0);
        host.sel();
        host.shift(20, 64'h0);
        check(host.rx[32:1], last_cfg);
        host.shift(8, 64'h55);
        host.shift(8, {56'h0, asp_pkg::CMD_READ_DATA});
        host.resync();
        host.read(asp_pkg::CMD_READ_CFG, r);
        check(r, last_cfg);
        check({31'h0, serial_out_oe}, 32'h1);
        host.desel();
        check({31'h0, serial_out_oe}, 32'h0);
        report_and_stop();
    end
endmodule // tb_top
